/* File: dv/tpr_bank_asserts.sv */
// Purpose: Bus and register-bank checks on the bank ports
// Assumes: One clock; reset high disables every check
// Notes:   Bench offers write address and data together
`timescale 1ns/1ps
`include "tpr_defines.vh"

module tpr_bank_asserts (
   // Clock and reset
   input wire                   clk,
   input wire                   reset,
   // Register bus
   input wire [`TPR_ADDR_W-1:0] s_axi_awaddr,
   input wire                   s_axi_awvalid,
   input wire                   s_axi_awready,
   input wire                   s_axi_wvalid,
   input wire                   s_axi_wready,
   input wire [1:0]             s_axi_bresp,
   input wire                   s_axi_bvalid,
   input wire                   s_axi_bready,
   input wire [`TPR_ADDR_W-1:0] s_axi_araddr,
   input wire                   s_axi_arvalid,
   input wire                   s_axi_arready,
   input wire [31:0]            s_axi_rdata,
   input wire [1:0]             s_axi_rresp,
   input wire                   s_axi_rvalid,
   input wire                   s_axi_rready,
   // Shaper side
   input wire [`TPR_GAIN_MSB:0] ch1_amplitude_gain_code
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // Register hits; any other index must answer with an error
   function automatic logic hit(input [5:0] i);
      hit = i inside {`TPR_IDX_GAIN_CH1, `TPR_IDX_CTRL_CH1, `TPR_IDX_WORD_CH1,
                      `TPR_IDX_GAIN_CH2, `TPR_IDX_CTRL_CH2, `TPR_IDX_WORD_CH2};
   endfunction
   wire aw_hit = hit(s_axi_awaddr[7:2]);
   wire ar_hit = hit(s_axi_araddr[7:2]);

   // Handshake steps
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_wr_answer: assert property (s_wr |=> ##1 s_axi_bvalid)
      else $error("write response missing");
   a_wr_okay: assert property (s_wr ##0 aw_hit |=> ##1 s_axi_bresp == `TPR_RESP_OKAY)
      else $error("mapped write not okay");
   a_wr_unmapped: assert property (s_wr ##0 !aw_hit |=> ##1 s_axi_bresp == `TPR_RESP_SLVERR)
      else $error("unmapped write not refused");
   a_resp_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rd_answer: assert property (s_rd |=> s_axi_rvalid ##0 s_axi_rdata[31:8] == 24'h0)
      else $error("read answer wrong");
   a_rd_unmapped: assert property (s_rd ##0 !ar_hit |=> s_axi_rresp == `TPR_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   // Gain copy may move only just after a write response
   a_gain_lag: assert property ($changed(ch1_amplitude_gain_code) |-> $past(s_axi_bvalid))
      else $error("gain moved without write");
endmodule

bind tpr_bank tpr_bank_asserts chk (.*);

/* File: dv/tpr_bank_test.sv */
// Purpose: Self-checking bench for the pulse template register bank
// Assumes: Bus tasks start one edge after the last ends
// Notes:   Both RAMs are filled before any readback
`timescale 1ns/1ps
`include "tpr_defines.vh"

module tpr_bank_test;
   // Stimulus and observed ports
   reg         clk = 1'b0;
   reg         reset = 1'b1;
   reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg  [5:0]  ch1_shp_addr = 6'h00, ch2_shp_addr = 6'h00;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [5:0]  ch1_amplitude_gain_code, ch2_amplitude_gain_code;
   wire [6:0]  ch1_shp_data, ch2_shp_data;
   integer     num_errors = 0, checked = 0, n, c, k;
   reg  [7:0]  d;
   reg  [1:0]  r;
   reg  [5:0]  a;
   reg  [23:0] rows [0:8];

   tpr_bank uut (.*);
   always #10 clk = ~clk;

   // Verdict
   task end_sim;
      begin
         $display("checked %0d num_errors %0d", checked, num_errors);
         if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task bail;
      begin
         num_errors = num_errors + 1;
         end_sim;
      end
   endtask
   task chk(input string nm, input [31:0] s, input [31:0] e);
      begin
         checked = checked + 1;
         if (s !== e) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
         end
      end
   endtask

   // Write; ready is held back one cycle so the response must stand
   task wr(input [5:0] i, input [7:0] v);
      begin
         @(posedge clk);
         s_axi_awaddr <= {i, 2'b00};
         s_axi_wdata <= {24'h0, v};
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         for (n = 0; n < 50; n = n + 1) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
               r = s_axi_bresp;
               s_axi_bready <= 1'b0;
               n = 99;
            end else if (s_axi_bvalid) s_axi_bready <= 1'b1;
         end
         if (n == 50) bail;
      end
   endtask
   task rd(input [5:0] i);
      begin
         @(posedge clk);
         s_axi_araddr <= {i, 2'b00};
         s_axi_arvalid <= 1'b1;
         for (n = 0; n < 50; n = n + 1) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
               r = s_axi_rresp;
               d = s_axi_rdata[7:0];
               s_axi_rready <= 1'b0;
               n = 99;
            end else if (s_axi_rvalid) s_axi_rready <= 1'b1;
         end
         if (n == 50) bail;
      end
   endtask
   // Busy flag must fall within a bounded number of polls
   task poll(input [5:0] i);
      integer m;
      begin
         m = 0;
         rd(i);
         while (d[7] !== 1'b0 && m < 20) begin
            rd(i);
            m = m + 1;
         end
         if (d[7] !== 1'b0) bail;
      end
   endtask
   task rst_chk;
      begin
         chk("gain1 out", ch1_amplitude_gain_code, `TPR_GAIN_RESET);
         chk("gain2 out", ch2_amplitude_gain_code, `TPR_GAIN_RESET);
         for (k = 0; k < 4; k = k + 1) begin
            rd({k[1], 4'b0011, k[0]});
            chk("reset value", d, k[0] ? 8'h00 : 8'h21);
         end
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      bail;
   end

   // Main sequence
   initial begin
      // Template select sits outside this bank; one row per recommended gain code here
      rows[0] = {`TPR_IDX_GAIN_CH1, 8'h36, 8'h36, `TPR_RESP_OKAY};
      rows[1] = {`TPR_IDX_GAIN_CH1, 8'hd1, 8'h11, `TPR_RESP_OKAY};
      rows[2] = {`TPR_IDX_GAIN_CH2, 8'h08, 8'h08, `TPR_RESP_OKAY};
      rows[3] = {`TPR_IDX_GAIN_CH2, 8'hc4, 8'h04, `TPR_RESP_OKAY};
      rows[4] = {`TPR_IDX_GAIN_CH2, 8'h21, 8'h21, `TPR_RESP_OKAY};
      rows[5] = {`TPR_IDX_WORD_CH1, 8'hff, 8'h7f, `TPR_RESP_OKAY};
      rows[6] = {`TPR_IDX_WORD_CH2, 8'h2a, 8'h2a, `TPR_RESP_OKAY};
      rows[7] = {6'h09, 8'h5a, 8'h00, `TPR_RESP_SLVERR};
      rows[8] = {6'h3f, 8'h5a, 8'h00, `TPR_RESP_SLVERR};
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rst_chk;
      for (k = 0; k < 9; k = k + 1) begin
         wr(rows[k][23:18], rows[k][17:10]);
         chk("bresp", r, rows[k][1:0]);
         rd(rows[k][23:18]);
         chk("rresp", r, rows[k][1:0]);
         chk("rdata", d, rows[k][9:2]);
         if (rows[k][23:18] == `TPR_IDX_GAIN_CH1) chk("gain1", ch1_amplitude_gain_code, rows[k][7:2]);
         if (rows[k][23:18] == `TPR_IDX_GAIN_CH2) chk("gain2", ch2_amplitude_gain_code, rows[k][7:2]);
      end
      // Byte lane zero off: answered, but nothing stored
      s_axi_wstrb <= 4'he;
      wr(`TPR_IDX_GAIN_CH1, 8'h3c);
      chk("strb bresp", r, `TPR_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(`TPR_IDX_GAIN_CH1);
      chk("strb gain", d, {2'b00, `TPR_GAIN_DS1_75});
      // Fill both RAMs first, so a stray cross-channel store shows on readback
      // word before trigger, held
      for (c = 0; c < 2; c = c + 1) begin
         for (k = 0; k < 8; k = k + 1) begin
            a = {k[2:1], {4{k[0]}}};
            wr({c[0], 1'b0, 4'h8}, {1'b0, c[0], a});
            wr({c[0], 1'b0, 4'h7}, {2'b10, a});
            poll({c[0], 1'b0, 4'h7});
         end
      end
      // Clear the word before each read so only the RAM can refill it
      for (c = 0; c < 2; c = c + 1) begin
         for (k = 0; k < 8; k = k + 1) begin
            a = {k[2:1], {4{k[0]}}};
            ch1_shp_addr <= a;
            ch2_shp_addr <= a;
            wr({c[0], 1'b0, 4'h8}, 8'h00);
            wr({c[0], 1'b0, 4'h7}, {2'b11, a});
            poll({c[0], 1'b0, 4'h7});
            chk("ctrl", d, {2'b01, a});
            chk("shaper", c ? ch2_shp_data : ch1_shp_data, {c[0], a});
            rd({c[0], 1'b0, 4'h8});
            chk("word", d, {1'b0, c[0], a});
         end
      end
      // Second reset in mid-run
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rst_chk;
      end_sim;
   end
endmodule

/* File: hw/tpr_bank.v */
// Purpose: Per-channel gain code and indirect template RAM access over AXI4-Lite
// Assumes: One 50 MHz clock, asynchronous active-high reset
// Notes:   Register at index N sits at byte address 4*N; bits above 7 read zero
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "tpr_defines.vh"

module tpr_bank (
   // Clock and reset
   input  wire                          clk,
   input  wire                          reset,
   // AXI4-Lite write address
   input  wire [`TPR_ADDR_W-1:0]        s_axi_awaddr,
   input  wire                          s_axi_awvalid,
   output wire                          s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]                   s_axi_wdata,
   input  wire [3:0]                    s_axi_wstrb,
   input  wire                          s_axi_wvalid,
   output wire                          s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]                    s_axi_bresp,
   output reg                           s_axi_bvalid,
   input  wire                          s_axi_bready,
   // AXI4-Lite read address
   input  wire [`TPR_ADDR_W-1:0]        s_axi_araddr,
   input  wire                          s_axi_arvalid,
   output wire                          s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0]                   s_axi_rdata,
   output reg  [1:0]                    s_axi_rresp,
   output reg                           s_axi_rvalid,
   input  wire                          s_axi_rready,
   // Shaper side, channel 1
   output reg  [`TPR_GAIN_MSB:0]        ch1_amplitude_gain_code,
   input  wire [`TPR_RAM_ADDR_W-1:0]    ch1_shp_addr,
   output wire [`TPR_WORD_MSB:0]        ch1_shp_data,
   // Shaper side, channel 2
   output reg  [`TPR_GAIN_MSB:0]        ch2_amplitude_gain_code,
   input  wire [`TPR_RAM_ADDR_W-1:0]    ch2_shp_addr,
   output wire [`TPR_WORD_MSB:0]        ch2_shp_data
);

   // Access engine states, one-hot
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_READ = 3'h2;
   localparam [2:0] ST_LOAD = 3'h4;

   // Write channel capture
   reg                       aw_held_reg;
   reg [`TPR_IDX_W-1:0]      aw_idx_reg;
   reg                       w_held_reg;
   reg [7:0]                 w_data_reg;
   reg                       w_strb_reg;

   // Per-channel registers, flattened two-wide
   reg [`TPR_GAIN_MSB:0]     gain_reg    [0:`TPR_NUM_CH-1];
   reg [`TPR_CTRL_TRIG-1:0]  ctrl_reg    [0:`TPR_NUM_CH-1];
   reg                       busy_reg    [0:`TPR_NUM_CH-1];
   reg [`TPR_WORD_MSB:0]     word_reg    [0:`TPR_NUM_CH-1];
   reg [2:0]                 state_reg   [0:`TPR_NUM_CH-1];

   wire                      ram_wr   [0:`TPR_NUM_CH-1];
   wire                      ram_rd   [0:`TPR_NUM_CH-1];
   wire [`TPR_WORD_MSB:0]    ram_q    [0:`TPR_NUM_CH-1];
   wire [`TPR_RAM_ADDR_W-1:0] shp_a   [0:`TPR_NUM_CH-1];
   wire [`TPR_WORD_MSB:0]    shp_q    [0:`TPR_NUM_CH-1];

   // Write commit: both halves held and no response outstanding
   wire                      wr_go;
   wire                      wr_hit_any;
   reg  [`TPR_NUM_CH-1:0]    hit_gain;
   reg  [`TPR_NUM_CH-1:0]    hit_ctrl;
   reg  [`TPR_NUM_CH-1:0]    hit_word;

   assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
   assign wr_go         = aw_held_reg & w_held_reg & ~s_axi_bvalid;

   // Decode of the held write index per channel
   always @* begin
      hit_gain = {`TPR_NUM_CH{1'b0}};
      hit_ctrl = {`TPR_NUM_CH{1'b0}};
      hit_word = {`TPR_NUM_CH{1'b0}};
      case (aw_idx_reg)
         `TPR_IDX_GAIN_CH1: hit_gain[0] = 1'b1;
         `TPR_IDX_CTRL_CH1: hit_ctrl[0] = 1'b1;
         `TPR_IDX_WORD_CH1: hit_word[0] = 1'b1;
         `TPR_IDX_GAIN_CH2: hit_gain[1] = 1'b1;
         `TPR_IDX_CTRL_CH2: hit_ctrl[1] = 1'b1;
         `TPR_IDX_WORD_CH2: hit_word[1] = 1'b1;
         default: begin
            hit_gain = {`TPR_NUM_CH{1'b0}};
         end
      endcase
   end

   assign wr_hit_any = |{hit_gain, hit_ctrl, hit_word};

   // Address and data may arrive in either order; each is held until both are
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         aw_held_reg  <= 1'b0;
         aw_idx_reg   <= {`TPR_IDX_W{1'b0}};
         w_held_reg   <= 1'b0;
         w_data_reg   <= 8'h00;
         w_strb_reg   <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `TPR_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[`TPR_ADDR_W-1:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_strb_reg <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit_any ? `TPR_RESP_OKAY : `TPR_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Per-channel register set, access engine and template store
   genvar c;
   generate
      for (c = 0; c < `TPR_NUM_CH; c = c + 1) begin : g_ch
         wire wr_lane = wr_go & w_strb_reg;
         wire trig = wr_lane & hit_ctrl[c] & w_data_reg[`TPR_CTRL_TRIG] & ~busy_reg[c];

         always @(posedge clk or posedge reset) begin
            if (reset) begin
               gain_reg[c] <= `TPR_GAIN_RESET;
            end else if (wr_lane && hit_gain[c]) begin
               gain_reg[c] <= w_data_reg[`TPR_GAIN_MSB:0];
            end
         end

         // direction and addresses; held while an access runs
         always @(posedge clk or posedge reset) begin
            if (reset) begin
               ctrl_reg[c] <= `TPR_CTRL_RESET;
            end else if (wr_lane && hit_ctrl[c] && !busy_reg[c]) begin
               ctrl_reg[c] <= w_data_reg[`TPR_CTRL_TRIG-1:0];
            end
         end

         // Access engine: write takes one cycle, read two
         always @(posedge clk or posedge reset) begin
            if (reset) begin
               state_reg[c] <= ST_IDLE;
               busy_reg[c]  <= 1'b0;
               word_reg[c]  <= `TPR_WORD_RESET;
            end else begin
               case (state_reg[c])
                  ST_IDLE: begin
                     if (trig) begin
                        busy_reg[c] <= 1'b1;
                        if (w_data_reg[`TPR_CTRL_DIR]) begin
                           state_reg[c] <= ST_READ;
                        end else begin
                           state_reg[c] <= ST_LOAD;
                        end
                     end else if (wr_lane && hit_word[c]) begin
                        word_reg[c] <= w_data_reg[`TPR_WORD_MSB:0];
                     end
                  end
                  ST_READ: begin
                     state_reg[c] <= ST_LOAD;
                  end
                  ST_LOAD: begin
                     if (ctrl_reg[c][`TPR_CTRL_DIR]) begin
                        word_reg[c] <= ram_q[c];
                     end
                     busy_reg[c]  <= 1'b0;
                     state_reg[c] <= ST_IDLE;
                  end
                  default: begin
                     state_reg[c] <= ST_IDLE;
                     busy_reg[c]  <= 1'b0;
                  end
               endcase
            end
         end

         // write stored word at the address
         assign ram_wr[c] = (state_reg[c] == ST_LOAD) & ~ctrl_reg[c][`TPR_CTRL_DIR];
         assign ram_rd[c] = (state_reg[c] == ST_READ);

         // interval and point form the RAM address
         tpr_template_ram u_ram (
            .clk      (clk),
            .wr_en    (ram_wr[c]),
            .rd_en    (ram_rd[c]),
            .addr     (ctrl_reg[c][`TPR_CTRL_UI_MSB:`TPR_CTRL_PT_LSB]),
            .wr_data  (word_reg[c]),
            .rd_data  (ram_q[c]),
            .shp_addr (shp_a[c]),
            .shp_data (shp_q[c])
         );
      end
   endgenerate

   assign shp_a[0]     = ch1_shp_addr;
   assign shp_a[1]     = ch2_shp_addr;
   assign ch1_shp_data = shp_q[0];
   assign ch2_shp_data = shp_q[1];

   // Gain codes to the shaper, from flip-flops
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         ch1_amplitude_gain_code <= `TPR_GAIN_RESET;
         ch2_amplitude_gain_code <= `TPR_GAIN_RESET;
      end else begin
         ch1_amplitude_gain_code <= gain_reg[0];
         ch2_amplitude_gain_code <= gain_reg[1];
      end
   end

   // Read path: trigger bit reads one while an access is still running
   reg [7:0] rd_val;
   reg       rd_hit;
   always @* begin
      rd_val = 8'h00;
      rd_hit = 1'b1;
      case (s_axi_araddr[`TPR_ADDR_W-1:2])
         `TPR_IDX_GAIN_CH1: rd_val = {2'h0, gain_reg[0]};
         `TPR_IDX_CTRL_CH1: rd_val = {busy_reg[0], ctrl_reg[0]};
         `TPR_IDX_WORD_CH1: rd_val = {1'b0, word_reg[0]};
         `TPR_IDX_GAIN_CH2: rd_val = {2'h0, gain_reg[1]};
         `TPR_IDX_CTRL_CH2: rd_val = {busy_reg[1], ctrl_reg[1]};
         `TPR_IDX_WORD_CH2: rd_val = {1'b0, word_reg[1]};
         default:           rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // Read answer one cycle after the address is taken
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `TPR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, rd_val};
         s_axi_rresp  <= rd_hit ? `TPR_RESP_OKAY : `TPR_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

/* File: hw/tpr_defines.vh */
// Purpose: Constants for the transmit pulse template register bank
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register
// Notes:   Printed offsets are not multiples of four, so they are indices
`ifndef TPR_DEFINES_VH
`define TPR_DEFINES_VH

// Register indices; byte address is four times the index
`define TPR_IDX_GAIN_CH1   6'h06
`define TPR_IDX_CTRL_CH1   6'h07
`define TPR_IDX_WORD_CH1   6'h08
`define TPR_IDX_GAIN_CH2   6'h26
`define TPR_IDX_CTRL_CH2   6'h27
`define TPR_IDX_WORD_CH2   6'h28
`define TPR_IDX_W          6
`define TPR_ADDR_W         8

// Gain register fields
`define TPR_GAIN_RESET     6'h21
`define TPR_GAIN_MSB       5
// Recommended gain codes per line setting
`define TPR_GAIN_T1_SH     6'h36
`define TPR_GAIN_DS1_75    6'h11
`define TPR_GAIN_DS1_150   6'h08
`define TPR_GAIN_DS1_225   6'h04
`define TPR_GAIN_E1        6'h21

// Control register fields
`define TPR_CTRL_TRIG      7
`define TPR_CTRL_DIR       6
`define TPR_CTRL_UI_MSB    5
`define TPR_CTRL_UI_LSB    4
`define TPR_CTRL_PT_MSB    3
`define TPR_CTRL_PT_LSB    0
`define TPR_CTRL_RESET     7'h00

// Amplitude word field
`define TPR_WORD_MSB       6
`define TPR_WORD_RESET     7'h00

// Template RAM geometry
`define TPR_RAM_ADDR_W     6
`define TPR_RAM_DEPTH      64
`define TPR_NUM_CH         2

// AXI responses
`define TPR_RESP_OKAY      2'h0
`define TPR_RESP_SLVERR    2'h2

`endif

/* File: hw/tpr_template_ram.v */
// Purpose: One channel's pulse template store, 4 unit intervals by 16 points
// Assumes: Single clock, synchronous write, registered read on the access port, direct read on the shaper port
// Notes:   Flip-flop storage, contents not reset
`timescale 1ns/1ps
`include "tpr_defines.vh"

module tpr_template_ram (
   // Clock
   input  wire                             clk,
   // Access port
   input  wire                             wr_en,
   input  wire                             rd_en,
   input  wire [`TPR_RAM_ADDR_W-1:0]       addr,
   input  wire [`TPR_WORD_MSB:0]           wr_data,
   output reg  [`TPR_WORD_MSB:0]           rd_data,
   // Shaper read port
   input  wire [`TPR_RAM_ADDR_W-1:0]       shp_addr,
   output wire [`TPR_WORD_MSB:0]           shp_data
);

   reg [`TPR_WORD_MSB:0] mem [0:`TPR_RAM_DEPTH-1];

   // Write and registered read; read of the old word when both hit
   always @(posedge clk) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[addr];
      end
   end

   // Shaper sees the stored sample directly
   assign shp_data = mem[shp_addr];

endmodule
